// File: hdl/opdec_pkg.sv
// Behaviour
// - Decode 0F escape special-register moves; 22/23/26 write, 20/21/24 read.
// - Decode 0F BE/BF as sign-extending load; low bit picks width, one clock.
// - Decode 0F B6/B7 as zero-extending load; one clock in both modes.
// - 0F FF is the designated invalid opcode; 1 clock real, 8-125 protected.
package opdec_pkg;

    // ==========================================
    // Opcode bytes
    localparam logic [7:0] ESCAPE_BYTE   = 8'h0f;
    localparam logic [7:0] OP_CR_READ    = 8'h20;
    localparam logic [7:0] OP_DR_READ    = 8'h21;
    localparam logic [7:0] OP_CR_WRITE   = 8'h22;
    localparam logic [7:0] OP_DR_WRITE   = 8'h23;
    localparam logic [7:0] OP_TR_READ    = 8'h24;
    localparam logic [7:0] OP_TR_WRITE   = 8'h26;
    localparam logic [6:0] OP_SX_UPPER   = 7'h5f;  // B[111w] without w
    localparam logic [6:0] OP_ZX_UPPER   = 7'h5b;  // B[011w] without w
    localparam logic [7:0] OP_INVALID    = 8'hff;
    localparam logic [1:0] MOD_REGISTER  = 2'h3;

    // ==========================================
    // Special-register indices with their own counts
    localparam logic [2:0] SREG_CR0_IDX  = 3'h0;
    localparam logic [2:0] SREG_CR4_IDX  = 3'h4;
    localparam logic [2:0] SREG_TR6_IDX  = 3'h6;  // TR6 and above take the short counts

    // ==========================================
    // Clock counts, real / protected (cache-hit)
    localparam logic [7:0] CLK_ONE       = 8'h01;
    localparam logic [7:0] CLK_CR_WRITE  = 8'h14;  // 20 real, 18 protected (CR0)
    localparam logic [7:0] CLK_CR_WR_P   = 8'h12;
    localparam logic [7:0] CLK_CR_WR_O   = 8'h05;  // CR2/CR3 real and protected
    localparam logic [7:0] CLK_CR4_WR_P  = 8'h06;
    localparam logic [7:0] CLK_CR_READ   = 8'h06;
    localparam logic [7:0] CLK_DR_WRITE  = 8'h0a;
    localparam logic [7:0] CLK_DR_READ   = 8'h09;
    localparam logic [7:0] CLK_TR35_WR   = 8'h10;
    localparam logic [7:0] CLK_TR35_RD   = 8'h08;
    localparam logic [7:0] CLK_TR67_WR   = 8'h0b;
    localparam logic [7:0] CLK_TR67_RD   = 8'h03;
    localparam logic [7:0] CLK_INV_MIN   = 8'h08;
    localparam logic [7:0] CLK_INV_MAX   = 8'h7d;

    // ==========================================
    // Decoded instruction classes
    typedef enum logic [2:0] {
        CLASS_NONE,
        CLASS_SPECIAL_WRITE,
        CLASS_SPECIAL_READ,
        CLASS_SIGN_EXTEND,
        CLASS_ZERO_EXTEND,
        CLASS_INVALID
    } op_class_t;

    typedef enum logic [1:0] {
        SREG_CONTROL,
        SREG_DEBUG,
        SREG_TEST
    } sreg_kind_t;

endpackage

// File: hdl/opdec_clock_table.sv
`timescale 1ns/1ps
module opdec_clock_table (
    input  wire logic [2:0] class_in,
    input  wire logic [1:0] kind_in,
    input  wire logic [2:0] sreg_in,
    input  wire logic       protected_in,
    output logic      [7:0] clocks_min_out,
    output logic      [7:0] clocks_max_out
);
    // ==========================================
    // Best-case counts; misses stall downstream
    logic [7:0] base;
    logic [7:0] top;
    always_comb begin
        base = opdec_pkg::CLK_ONE;
        top  = opdec_pkg::CLK_ONE;
        case (opdec_pkg::op_class_t'(class_in))
            opdec_pkg::CLASS_SPECIAL_WRITE: begin
                if (kind_in == 2'(opdec_pkg::SREG_CONTROL)) begin
                    if (sreg_in == opdec_pkg::SREG_CR0_IDX) begin
                        base = protected_in ? opdec_pkg::CLK_CR_WR_P
                                            : opdec_pkg::CLK_CR_WRITE;
                    end else if (sreg_in == opdec_pkg::SREG_CR4_IDX && protected_in) begin
                        base = opdec_pkg::CLK_CR4_WR_P;
                    end else begin
                        base = opdec_pkg::CLK_CR_WR_O;
                    end
                end else if (kind_in == 2'(opdec_pkg::SREG_DEBUG)) begin
                    base = opdec_pkg::CLK_DR_WRITE;
                end else begin
                    base = (sreg_in >= opdec_pkg::SREG_TR6_IDX) ? opdec_pkg::CLK_TR67_WR
                                                                : opdec_pkg::CLK_TR35_WR;
                end
                top = base;
            end
            opdec_pkg::CLASS_SPECIAL_READ: begin
                if (kind_in == 2'(opdec_pkg::SREG_CONTROL)) begin
                    base = opdec_pkg::CLK_CR_READ;
                end else if (kind_in == 2'(opdec_pkg::SREG_DEBUG)) begin
                    base = opdec_pkg::CLK_DR_READ;
                end else begin
                    base = (sreg_in >= opdec_pkg::SREG_TR6_IDX) ? opdec_pkg::CLK_TR67_RD
                                                                : opdec_pkg::CLK_TR35_RD;
                end
                top = base;
            end
            opdec_pkg::CLASS_INVALID: begin
                base = protected_in ? opdec_pkg::CLK_INV_MIN : opdec_pkg::CLK_ONE;
                top  = protected_in ? opdec_pkg::CLK_INV_MAX : opdec_pkg::CLK_ONE;
            end
            default: begin
                base = opdec_pkg::CLK_ONE;
                top  = opdec_pkg::CLK_ONE;
            end
        endcase
    end

    assign clocks_min_out = base;
    assign clocks_max_out = top;
endmodule

// File: hdl/core_opcode_decode_slice.sv
`timescale 1ns/1ps
module core_opcode_decode_slice (
    input  wire logic       sys_clk_in,
    input  wire logic       rstn_in,
    input  wire logic       valid_in,
    input  wire logic [7:0] byte0_in,
    input  wire logic [7:0] byte1_in,
    input  wire logic [7:0] modrm_in,
    input  wire logic       protected_in,
    output logic            valid_out,
    output logic      [2:0] class_out,
    output logic            ext_word_src_out,
    output logic      [1:0] sreg_kind_out,
    output logic      [2:0] sreg_index_out,
    output logic      [2:0] gpr_index_out,
    output logic      [7:0] clocks_min_out,
    output logic      [7:0] clocks_max_out
);
    // ==========================================
    // Combinational decode
    wire        is_escape  = (byte0_in == opdec_pkg::ESCAPE_BYTE);
    wire        reg_mode   = (modrm_in[7:6] == opdec_pkg::MOD_REGISTER);
    wire        sp_write   = is_escape && reg_mode &&
                             (byte1_in == opdec_pkg::OP_CR_WRITE ||
                              byte1_in == opdec_pkg::OP_DR_WRITE ||
                              byte1_in == opdec_pkg::OP_TR_WRITE);
    wire        sp_read    = is_escape && reg_mode &&
                             (byte1_in == opdec_pkg::OP_CR_READ ||
                              byte1_in == opdec_pkg::OP_DR_READ ||
                              byte1_in == opdec_pkg::OP_TR_READ);
    wire        sign_ext   = is_escape && (byte1_in[7:1] == opdec_pkg::OP_SX_UPPER);
    wire        zero_ext   = is_escape && (byte1_in[7:1] == opdec_pkg::OP_ZX_UPPER);
    wire        invalid_op = is_escape && (byte1_in == opdec_pkg::OP_INVALID);
    // Low three bits of the second byte tell control, debug and test apart
    wire [1:0]  kind       = (byte1_in[2:0] == opdec_pkg::OP_CR_WRITE[2:0] ||
                              byte1_in[2:0] == opdec_pkg::OP_CR_READ[2:0]) ?
                             2'(opdec_pkg::SREG_CONTROL) :
                             (byte1_in[2:0] == opdec_pkg::OP_DR_WRITE[2:0] ||
                              byte1_in[2:0] == opdec_pkg::OP_DR_READ[2:0]) ?
                             2'(opdec_pkg::SREG_DEBUG) : 2'(opdec_pkg::SREG_TEST);
    wire [2:0]  next_class = !valid_in  ? 3'(opdec_pkg::CLASS_NONE) :
                             sp_write   ? 3'(opdec_pkg::CLASS_SPECIAL_WRITE) :
                             sp_read    ? 3'(opdec_pkg::CLASS_SPECIAL_READ) :
                             sign_ext   ? 3'(opdec_pkg::CLASS_SIGN_EXTEND) :
                             zero_ext   ? 3'(opdec_pkg::CLASS_ZERO_EXTEND) :
                             invalid_op ? 3'(opdec_pkg::CLASS_INVALID) :
                                          3'(opdec_pkg::CLASS_NONE);
    // Special moves: eee field picks the register, r/m the general one
    wire        is_special = sp_write || sp_read;
    wire [2:0]  next_gpr   = is_special ? modrm_in[2:0] : modrm_in[5:3];
    wire [7:0]  next_min;
    wire [7:0]  next_max;

    opdec_clock_table u_table (
        .class_in       (next_class),
        .kind_in        (kind),
        .sreg_in        (modrm_in[5:3]),
        .protected_in   (protected_in),
        .clocks_min_out (next_min),
        .clocks_max_out (next_max)
    );

    // ==========================================
    // Registered outputs
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            valid_out        <= 1'b0;
            class_out        <= 3'(opdec_pkg::CLASS_NONE);
            ext_word_src_out <= 1'b0;
            sreg_kind_out    <= 2'(opdec_pkg::SREG_CONTROL);
            sreg_index_out   <= 3'h0;
            gpr_index_out    <= 3'h0;
            clocks_min_out   <= opdec_pkg::CLK_ONE;
            clocks_max_out   <= opdec_pkg::CLK_ONE;
        end else begin
            valid_out        <= next_class != 3'(opdec_pkg::CLASS_NONE);
            class_out        <= next_class;
            ext_word_src_out <= byte1_in[0];
            sreg_kind_out    <= kind;
            sreg_index_out   <= modrm_in[5:3];
            gpr_index_out    <= next_gpr;
            clocks_min_out   <= next_min;
            clocks_max_out   <= next_max;
        end
    end

    // ==========================================
    // Checks
    a_special_write: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        valid_in && sp_write |=> class_out == 3'(opdec_pkg::CLASS_SPECIAL_WRITE))
        else $error("special write not decoded");
    a_sign_one_clk: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        valid_in && sign_ext |=> clocks_max_out == opdec_pkg::CLK_ONE &&
        ext_word_src_out == $past(byte1_in[0]))
        else $error("sign extend wrong");
    a_zero_one_clk: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        valid_in && zero_ext |=> class_out == 3'(opdec_pkg::CLASS_ZERO_EXTEND) &&
        clocks_min_out == opdec_pkg::CLK_ONE)
        else $error("zero extend wrong");
    a_invalid_range: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        valid_in && invalid_op && protected_in |=>
        clocks_min_out == opdec_pkg::CLK_INV_MIN &&
        clocks_max_out == opdec_pkg::CLK_INV_MAX)
        else $error("invalid opcode count wrong");
    a_best_case: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        valid_out |-> clocks_min_out <= clocks_max_out)
        else $error("count range inverted");

    // Reset clears every output to its idle value on the next edge
    a_reset_idle: assert property (@(posedge sys_clk_in)
        !rstn_in |=> !valid_out && class_out == 3'(opdec_pkg::CLASS_NONE) &&
        clocks_min_out == opdec_pkg::CLK_ONE &&
        clocks_max_out == opdec_pkg::CLK_ONE)
        else $error("outputs not idle after reset");

    // Valid and class must always agree
    a_valid_class: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        valid_out == (class_out != 3'(opdec_pkg::CLASS_NONE)))
        else $error("valid and class disagree");

    // An idle cycle never produces a decoded instruction
    a_idle_quiet: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        !valid_in |=> !valid_out)
        else $error("decode without valid input");

    // Without the escape byte nothing in this slice is recognised
    a_no_escape: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        byte0_in != opdec_pkg::ESCAPE_BYTE |=> !valid_out)
        else $error("decode without escape byte");

    // Special reads decode as reads
    a_special_read: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        valid_in && sp_read |=> class_out == 3'(opdec_pkg::CLASS_SPECIAL_READ))
        else $error("special read not decoded");

    // Memory-form special moves are refused
    a_special_mem: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        valid_in && is_escape && !reg_mode &&
        (byte1_in == opdec_pkg::OP_CR_WRITE || byte1_in == opdec_pkg::OP_TR_READ) |=>
        !valid_out)
        else $error("memory-form special move accepted");

    // Middle field picks the special register, low field the general one
    a_special_fields: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        valid_in && is_special |=> sreg_index_out == $past(modrm_in[5:3]) &&
        gpr_index_out == $past(modrm_in[2:0]))
        else $error("special move fields wrong");

    // Debug moves carry the debug kind
    a_debug_kind: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        valid_in && is_special && (byte1_in == opdec_pkg::OP_DR_WRITE ||
        byte1_in == opdec_pkg::OP_DR_READ) |=>
        sreg_kind_out == 2'(opdec_pkg::SREG_DEBUG))
        else $error("debug kind wrong");

    // Test moves carry the test kind
    a_test_kind: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        valid_in && is_special && (byte1_in == opdec_pkg::OP_TR_WRITE ||
        byte1_in == opdec_pkg::OP_TR_READ) |=>
        sreg_kind_out == 2'(opdec_pkg::SREG_TEST))
        else $error("test kind wrong");

    // CR0 write depends on the mode
    a_cr0_write: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        valid_in && sp_write && byte1_in == opdec_pkg::OP_CR_WRITE &&
        modrm_in[5:3] == opdec_pkg::SREG_CR0_IDX |=>
        clocks_min_out == ($past(protected_in) ? opdec_pkg::CLK_CR_WR_P
                                               : opdec_pkg::CLK_CR_WRITE))
        else $error("control write count wrong");

    // Debug read counts do not depend on the mode
    a_debug_counts: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        valid_in && sp_read && byte1_in == opdec_pkg::OP_DR_READ |=>
        clocks_min_out == opdec_pkg::CLK_DR_READ &&
        clocks_max_out == opdec_pkg::CLK_DR_READ)
        else $error("debug read count wrong");

    // Control reads take a fixed count
    a_control_read: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        valid_in && sp_read && byte1_in == opdec_pkg::OP_CR_READ |=>
        clocks_max_out == opdec_pkg::CLK_CR_READ)
        else $error("control read count wrong");

    // Sign-extending loads take the sign class and keep the destination
    a_sign_class: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        valid_in && sign_ext |=> class_out == 3'(opdec_pkg::CLASS_SIGN_EXTEND) &&
        gpr_index_out == $past(modrm_in[5:3]))
        else $error("sign extend class wrong");

    // Zero-extending loads report the width bit as given
    a_zero_width: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        valid_in && zero_ext |=> ext_word_src_out == $past(byte1_in[0]) &&
        clocks_max_out == opdec_pkg::CLK_ONE)
        else $error("zero extend width wrong");

    // Invalid opcode in real mode is a single clock
    a_invalid_real: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        valid_in && invalid_op && !protected_in |=>
        class_out == 3'(opdec_pkg::CLASS_INVALID) &&
        clocks_max_out == opdec_pkg::CLK_ONE)
        else $error("invalid opcode real count wrong");

    c_special_read: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
        class_out == 3'(opdec_pkg::CLASS_SPECIAL_READ));
    c_sign_ext: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
        class_out == 3'(opdec_pkg::CLASS_SIGN_EXTEND));
    c_invalid_prot: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
        clocks_max_out == opdec_pkg::CLK_INV_MAX);
    c_zero_ext: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
        class_out == 3'(opdec_pkg::CLASS_ZERO_EXTEND));
    c_special_write: cover property (@(posedge sys_clk_in) disable iff (!rstn_in)
        class_out == 3'(opdec_pkg::CLASS_SPECIAL_WRITE));
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
    logic       sys_clk_in, rstn_in, valid_in, protected_in, valid_out, ext_word_src_out;
    logic [7:0] byte0_in, byte1_in, modrm_in, clocks_min_out, clocks_max_out;
    logic [2:0] class_out, sreg_index_out, gpr_index_out;
    logic [1:0] sreg_kind_out;
    int         fails, compares;

    core_opcode_decode_slice DUT (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
        .valid_in(valid_in), .byte0_in(byte0_in), .byte1_in(byte1_in),
        .modrm_in(modrm_in), .protected_in(protected_in), .valid_out(valid_out),
        .class_out(class_out), .ext_word_src_out(ext_word_src_out),
        .sreg_kind_out(sreg_kind_out), .sreg_index_out(sreg_index_out),
        .gpr_index_out(gpr_index_out), .clocks_min_out(clocks_min_out),
        .clocks_max_out(clocks_max_out));

    // ==========================================
    // Clock, 20 ns period
    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end

    // ==========================================
    // Shared drive and compare tasks
    task automatic compare(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Present one instruction at a falling edge; outputs settle by the next one
    task automatic issue(input logic v, input logic [7:0] b1, input logic [7:0] m, input logic p);
        valid_in = v;
        byte0_in = 8'h0f;
        byte1_in = b1;
        modrm_in = m;
        protected_in = p;
        @(negedge sys_clk_in);
    endtask

    task automatic expect_out(input logic v, input logic [2:0] c, input logic [7:0] mn,
                              input logic [7:0] mx);
        compare({7'h00, valid_out}, {7'h00, v}, "valid");
        compare({5'h00, class_out}, {5'h00, c}, "class");
        compare(clocks_min_out, mn, "min clocks");
        compare(clocks_max_out, mx, "max clocks");
    endtask

    // Best-case count of a special-register move
    function automatic logic [7:0] sreg_clocks(int k, bit wr, int i, bit p);
        if (k == 0) return !wr ? 8'h06 : (i == 0) ? (p ? 8'h12 : 8'h14) : (i == 4 && p) ? 8'h06 : 8'h05;
        if (k == 1) return wr ? 8'h0a : 8'h09;
        return (i >= 6) ? (wr ? 8'h0b : 8'h03) : (wr ? 8'h10 : 8'h08);
    endfunction

    // ==========================================
    // Scenarios
    task automatic special_moves();
        logic [7:0] codes [6] = '{8'h22, 8'h23, 8'h26, 8'h20, 8'h21, 8'h24};
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 6; c++) begin
                for (int i = 0; i < 8; i++) begin
                    if ((c % 3 == 0 && (i == 1 || i > 4)) || (c % 3 == 2 && i < 3)) continue;
                    issue(1'b1, codes[c], {2'h3, 3'(i), 3'(5 ^ i)}, 1'(p));
                    expect_out(1'b1, (c < 3) ? 3'h1 : 3'h2, sreg_clocks(c % 3, c < 3, i, p),
                               sreg_clocks(c % 3, c < 3, i, p));
                    compare({6'h00, sreg_kind_out}, 8'(c % 3), "kind");
                    compare({5'h00, sreg_index_out}, 8'(i), "sreg index");
                    compare({5'h00, gpr_index_out}, 8'(5 ^ i), "gpr index");
                end
            end
        end
    endtask

    task automatic extend_moves();
        logic [7:0] codes [4] = '{8'hbe, 8'hbf, 8'hb6, 8'hb7};
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 4; c++) begin
                for (int m = 0; m < 4; m++) begin
                    issue(1'b1, codes[c], {2'(m), 3'(m + 2), 3'h1}, 1'(p));
                    expect_out(1'b1, (c < 2) ? 3'h3 : 3'h4, 8'h01, 8'h01);
                    compare({7'h00, ext_word_src_out}, 8'(c % 2), "word src");
                    compare({5'h00, gpr_index_out}, 8'(m + 2), "dest reg");
                end
            end
        end
    endtask

    task automatic invalid_opcode();
        issue(1'b1, 8'hff, 8'h00, 1'b0);
        expect_out(1'b1, 3'h5, 8'h01, 8'h01);
        issue(1'b1, 8'hff, 8'h00, 1'b1);
        expect_out(1'b1, 3'h5, 8'h08, 8'h7d);
    endtask

    // Memory-form special move, unknown code, idle cycle, missing escape byte, then reset mid-run
    task automatic refusals();
        issue(1'b1, 8'h22, 8'h40, 1'b0);
        expect_out(1'b0, 3'h0, 8'h01, 8'h01);
        issue(1'b1, 8'h90, 8'hc0, 1'b1);
        compare({7'h00, valid_out}, 8'h00, "unknown code");
        issue(1'b0, 8'hbe, 8'hc0, 1'b0);
        compare({7'h00, valid_out}, 8'h00, "idle");
        valid_in = 1'b1;
        byte0_in = 8'h66;
        @(negedge sys_clk_in);
        compare({7'h00, valid_out}, 8'h00, "no escape");
        rstn_in = 1'b0;
        issue(1'b1, 8'hff, 8'h00, 1'b1);
        expect_out(1'b0, 3'h0, 8'h01, 8'h01);
        rstn_in = 1'b1;
        issue(1'b1, 8'hb7, 8'hc0, 1'b1);
        expect_out(1'b1, 3'h4, 8'h01, 8'h01);
    endtask

    task automatic results();
        $display("comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        fails = 0;
        compares = 0;
        rstn_in = 1'b0;
        valid_in = 1'b0;
        byte0_in = 8'h00;
        byte1_in = 8'h00;
        modrm_in = 8'h00;
        protected_in = 1'b0;
        repeat (2) @(negedge sys_clk_in);
        expect_out(1'b0, 3'h0, 8'h01, 8'h01);
        rstn_in = 1'b1;
        special_moves();
        extend_moves();
        invalid_opcode();
        refusals();
        results();
    end
endmodule
